// File: hdl/phy_mgmt_map.vh
// register addresses, control-register fields, reset values and timing counts
`ifndef PHY_MGMT_MAP_VH
`define PHY_MGMT_MAP_VH

// ****************************************
// register addresses
// ****************************************
`define ADDR_BASIC_CONTROL     5'h00
`define ADDR_BASIC_STATUS      5'h01
`define ADDR_IDENTIFIER_HIGH   5'h02
`define ADDR_IDENTIFIER_LOW    5'h03
`define ADDR_EXT_ACCESS_CTL    5'h0d
`define ADDR_EXT_ACCESS_DATA   5'h0e

// ****************************************
// control register fields
// ****************************************
`define CTL_SOFT_RESET         15
`define CTL_LOOPBACK           14
`define CTL_SPEED_LOW          13
`define CTL_AUTONEG            12
`define CTL_POWER_DOWN         11
`define CTL_ISOLATE            10
`define CTL_RESERVED9          9
`define CTL_DUPLEX             8
`define CTL_COLLISION_TEST     7
`define CTL_SPEED_HIGH         6
`define CTL_UNIDIR             5

// ****************************************
// reset values and status bit positions
// ****************************************
`define RST_BASIC_CONTROL      16'h1100
`define RST_BASIC_STATUS       16'h1009
`define RST_EXT_ACCESS         16'h0000
`define STATUS_LINK_BIT        2
`define STATUS_AN_DONE_BIT     5

// ****************************************
// timing
// ****************************************
`define SOFT_RESET_NS          1000
`define CLK_PERIOD_NS          4
`define SOFT_RESET_CYCLES      ((`SOFT_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: hdl/mirror_bit.v
// one control bit that can be written from two places and reads the same from both
`timescale 1ns/1ps
module mirror_bit #(
    parameter RESET_VALUE = 1'b0
) (
    input  wire mclk,
    input  wire arst_n,
    input  wire loadReset,
    input  wire resetValue,
    input  wire writeA,
    input  wire dataA,
    input  wire writeB,
    input  wire dataB,
    output reg  value
);
    // a soft reset reloads the bit; port a wins a same-cycle write clash
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            value <= RESET_VALUE;
        end else if (loadReset) begin
            value <= resetValue;
        end else if (writeA) begin
            value <= dataA;
        end else if (writeB) begin
            value <= dataB;
        end
    end
endmodule // mirror_bit

// File: hdl/soft_reset_timer.v
// counts out a software reset cycle and reports when it ends
`timescale 1ns/1ps
module soft_reset_timer #(
    parameter CYCLES = 250,
    parameter WIDTH  = 16
) (
    input  wire mclk,
    input  wire arst_n,
    input  wire start,
    output reg  busy,
    output reg  done
);
    reg [WIDTH-1:0] count;

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            busy  <= 1'b0;
            done  <= 1'b0;
            count <= {WIDTH{1'b0}};
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                busy  <= 1'b1;
                count <= CYCLES[WIDTH-1:0] - {{(WIDTH-1){1'b0}}, 1'b1};
            end else if (busy) begin
                if (count == {WIDTH{1'b0}}) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // soft_reset_timer

// File: hdl/phy_clause22_mgmt_regs.v
// management register set of a single-pair 10 Mbps PHY: control, status, identifiers, extended access
`timescale 1ns/1ps
`include "phy_mgmt_map.vh"
module phy_clause22_mgmt_regs #(
    parameter [15:0] IDENTIFIER_HIGH   = 16'h1234,   // arbitrary value
    parameter [15:0] IDENTIFIER_LOW    = 16'h5678,   // arbitrary value
    parameter        SOFT_RESET_CYCLES = `SOFT_RESET_CYCLES
) (
    input  wire        mclk,
    input  wire        arst_n,
    input  wire        powerDownStrap,
    input  wire [4:0]  regAddr,
    input  wire        regWrite,
    input  wire [15:0] regWriteData,
    input  wire        regRead,
    input  wire        internalLoopbackWrite,
    input  wire        internalLoopbackData,
    input  wire        internalPowerDownWrite,
    input  wire        internalPowerDownData,
    input  wire        internalSoftResetWrite,
    input  wire        internal_autoneg_enable,
    input  wire        linkUp,
    input  wire        autonegDone,
    output reg  [15:0] regReadData,
    output reg         regReadValid,
    output reg         internal_soft_reset_ctl,
    output reg         internal_pcs_loopback_ctl,
    output reg         internal_power_down_ctl,
    output reg         mii_isolate_ctl,
    output reg         phyResetActive,
    output reg  [15:0] extended_access_control,
    output reg  [15:0] extended_access_data
);
    // ****************************************
    // decode
    // ****************************************
    wire selControl = (regAddr == `ADDR_BASIC_CONTROL);
    wire selStatus  = (regAddr == `ADDR_BASIC_STATUS);
    wire selIdHigh  = (regAddr == `ADDR_IDENTIFIER_HIGH);
    wire selIdLow   = (regAddr == `ADDR_IDENTIFIER_LOW);
    wire selExtCtl  = (regAddr == `ADDR_EXT_ACCESS_CTL);
    wire selExtData = (regAddr == `ADDR_EXT_ACCESS_DATA);

    wire writeControl = regWrite && selControl;

    // ****************************************
    // soft reset cycle
    // ****************************************
    wire resetStart = (writeControl && regWriteData[`CTL_SOFT_RESET]) || internalSoftResetWrite;
    wire timerBusy;
    wire timerDone;

    soft_reset_timer #(
        .CYCLES (SOFT_RESET_CYCLES),
        .WIDTH  (16)
    ) u_timer (
        .mclk   (mclk),
        .arst_n (arst_n),
        .start  (resetStart),
        .busy   (timerBusy),
        .done   (timerDone)
    );

    // first cycle after release: load power-down from the strap
    // (keeps the async reset branch free of a pin value)
    reg releaseSeen;
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            releaseSeen <= 1'b0;
        end else begin
            releaseSeen <= 1'b1;
        end
    end
    wire strapLoad = !releaseSeen || timerDone;

    // ****************************************
    // shared control bits, isolate and link status latch
    // ****************************************
    wire loopbackValue;
    wire powerDownValue;

    mirror_bit #(.RESET_VALUE(1'b0)) u_loopback (
        .mclk       (mclk),
        .arst_n     (arst_n),
        .loadReset  (timerDone),
        .resetValue (1'b0),
        .writeA     (writeControl),
        .dataA      (regWriteData[`CTL_LOOPBACK]),
        .writeB     (internalLoopbackWrite),
        .dataB      (internalLoopbackData),
        .value      (loopbackValue)
    );

    mirror_bit #(.RESET_VALUE(1'b0)) u_power_down (
        .mclk       (mclk),
        .arst_n     (arst_n),
        .loadReset  (strapLoad),
        .resetValue (powerDownStrap),
        .writeA     (writeControl),
        .dataA      (regWriteData[`CTL_POWER_DOWN]),
        .writeB     (internalPowerDownWrite),
        .dataB      (internalPowerDownData),
        .value      (powerDownValue)
    );

    reg isolate;
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            isolate <= 1'b0;
        end else if (timerDone) begin
            isolate <= 1'b0;
        end else if (writeControl) begin
            isolate <= regWriteData[`CTL_ISOLATE];
        end
    end

    // link status goes low with linkUp and sets again one cycle after linkUp returns, read or not
    reg linkLatched;
    wire readStatus = regRead && selStatus;
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            linkLatched <= 1'b0;
        end else if (!linkUp) begin
            linkLatched <= 1'b0;
        end else if (readStatus || !linkLatched) begin
            linkLatched <= 1'b1;
        end
    end

    // ****************************************
    // read view
    // ****************************************
    reg [15:0] controlView;
    always @* begin
        controlView                      = 16'h0000;
        controlView[`CTL_SOFT_RESET]     = timerBusy;
        controlView[`CTL_LOOPBACK]       = loopbackValue;
        controlView[`CTL_SPEED_LOW]      = 1'b0;
        controlView[`CTL_AUTONEG]        = internal_autoneg_enable;
        controlView[`CTL_POWER_DOWN]     = powerDownValue;
        controlView[`CTL_ISOLATE]        = isolate;
        controlView[`CTL_RESERVED9]      = 1'b0;
        controlView[`CTL_DUPLEX]         = 1'b1;
        controlView[`CTL_COLLISION_TEST] = 1'b0;
        controlView[`CTL_SPEED_HIGH]     = 1'b0;
        controlView[`CTL_UNIDIR]         = 1'b0;
    end

    reg [15:0] statusView;
    always @* begin
        statusView                      = `RST_BASIC_STATUS;
        statusView[`STATUS_LINK_BIT]    = linkLatched && linkUp;
        statusView[`STATUS_AN_DONE_BIT] = autonegDone;
    end

    reg [15:0] next_readData;
    always @* begin
        next_readData = 16'h0000;
        if (selControl) begin
            next_readData = controlView;
        end else if (selStatus) begin
            next_readData = statusView;
        end else if (selIdHigh) begin
            next_readData = IDENTIFIER_HIGH;
        end else if (selIdLow) begin
            next_readData = IDENTIFIER_LOW;
        end else if (selExtCtl) begin
            next_readData = extended_access_control;
        end else if (selExtData) begin
            next_readData = extended_access_data;
        end
    end

    // ****************************************
    // registered outputs
    // ****************************************
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            regReadData               <= 16'h0000;
            regReadValid              <= 1'b0;
            internal_soft_reset_ctl   <= 1'b0;
            internal_pcs_loopback_ctl <= 1'b0;
            internal_power_down_ctl   <= 1'b0;
            mii_isolate_ctl           <= 1'b0;
            phyResetActive            <= 1'b0;
            extended_access_control   <= `RST_EXT_ACCESS;
            extended_access_data      <= `RST_EXT_ACCESS;
        end else begin
            regReadValid <= regRead;
            if (regRead) begin
                regReadData <= next_readData;
            end
            internal_soft_reset_ctl   <= timerBusy;
            internal_pcs_loopback_ctl <= loopbackValue;
            internal_power_down_ctl   <= powerDownValue;
            mii_isolate_ctl           <= isolate;
            phyResetActive            <= timerBusy;
            // the end of a soft reset clears both extended access registers; bus access keeps working throughout
            if (timerDone) begin
                extended_access_control <= `RST_EXT_ACCESS;
                extended_access_data    <= `RST_EXT_ACCESS;
            end else if (regWrite && selExtCtl) begin
                extended_access_control <= regWriteData;
            end else if (regWrite && selExtData) begin
                extended_access_data <= regWriteData;
            end
        end
    end
endmodule // phy_clause22_mgmt_regs

// File: verification/mgmt_regs_assertions.sv
// checker for the management register set ports
`timescale 1ns/1ps
module mgmt_regs_checker #(
    parameter [15:0] IDENTIFIER_HIGH = 16'h1234,
    parameter [15:0] IDENTIFIER_LOW  = 16'h5678
) (
    input wire logic        mclk,
    input wire logic        arst_n,
    input wire logic [4:0]  regAddr,
    input wire logic        regWrite,
    input wire logic [15:0] regWriteData,
    input wire logic        regRead,
    input wire logic        internal_autoneg_enable,
    input wire logic [15:0] regReadData,
    input wire logic        regReadValid,
    input wire logic        internal_soft_reset_ctl,
    input wire logic        internal_pcs_loopback_ctl,
    input wire logic        mii_isolate_ctl,
    input wire logic        phyResetActive
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    wire ctlRead = regRead && regAddr == 5'h00;
    wire ctlWrite = regWrite && regAddr == 5'h00;
    wire known = regAddr <= 5'h03 || regAddr == 5'h0d || regAddr == 5'h0e;
    a_read_answer: assert property (regRead |=> regReadValid)
        else $error("read not answered");
    a_valid_cause: assert property (regReadValid |-> $past(regRead))
        else $error("answer without read");
    a_fixed_bits: assert property (ctlRead |=> (regReadData & 16'h23ff) == 16'h0100)
        else $error("fixed control bits wrong");
    a_autoneg_view: assert property (ctlRead |=> regReadData[12] == $past(internal_autoneg_enable))
        else $error("autoneg view wrong");
    a_ident_high: assert property (regRead && regAddr == 5'h02 |=> regReadData == IDENTIFIER_HIGH)
        else $error("identifier wrong");
    a_ident_low: assert property (regRead && regAddr == 5'h03 |=> regReadData == IDENTIFIER_LOW)
        else $error("low identifier wrong");
    a_undecoded_zero: assert property (regRead && !known |=> regReadData == 16'h0000)
        else $error("undecoded read not zero");
    a_loop_follow: assert property (ctlWrite && !regWriteData[15] |-> ##2
        internal_pcs_loopback_ctl == $past(regWriteData[14], 2))
        else $error("loopback output wrong");
    a_isolate_follow: assert property (ctlWrite && !regWriteData[15] |-> ##2
        mii_isolate_ctl == $past(regWriteData[10], 2))
        else $error("isolate output wrong");
    a_reset_start: assert property (ctlWrite && regWriteData[15] |-> ##[1:2] internal_soft_reset_ctl)
        else $error("soft reset not started");
    a_reset_ends: assert property ($rose(internal_soft_reset_ctl) |-> ##[1:1000] !internal_soft_reset_ctl)
        else $error("soft reset never ends");
    a_reset_same: assert property (phyResetActive == internal_soft_reset_ctl)
        else $error("reset flags differ");
    a_reset_clears: assert property ($fell(internal_soft_reset_ctl) |=>
        !internal_pcs_loopback_ctl && !mii_isolate_ctl)
        else $error("soft reset left loopback or isolate set");
    cover property (ctlWrite && regWriteData[15]);
    cover property (regRead && !known);
    cover property (ctlRead);
endmodule // mgmt_regs_checker
bind phy_clause22_mgmt_regs mgmt_regs_checker #(.IDENTIFIER_HIGH(IDENTIFIER_HIGH),
    .IDENTIFIER_LOW(IDENTIFIER_LOW)) check (
    .mclk(mclk), .arst_n(arst_n), .regAddr(regAddr), .regWrite(regWrite),
    .regWriteData(regWriteData), .regRead(regRead), .internal_autoneg_enable(internal_autoneg_enable),
    .regReadData(regReadData), .regReadValid(regReadValid), .internal_soft_reset_ctl(internal_soft_reset_ctl),
    .internal_pcs_loopback_ctl(internal_pcs_loopback_ctl), .mii_isolate_ctl(mii_isolate_ctl),
    .phyResetActive(phyResetActive));

// File: verification/mgmt_host.sv
// station management host model driving the register bus
`timescale 1ns/1ps
module mgmt_host (
    input  wire        mclk,
    input  wire [15:0] regReadData,
    input  wire        regReadValid,
    output reg  [4:0]  regAddr,
    output reg         regWrite,
    output reg  [15:0] regWriteData,
    output reg         regRead
);
    initial begin
        regAddr = 5'h00;
        regWrite = 1'b0;
        regWriteData = 16'h0000;
        regRead = 1'b0;
    end
    // only bit 15 starts a reset; wr sends bit 12 as given, clear in the 16'h0000 and 16'hcc00 writes
    task wr(input [4:0] a, input [15:0] d);
        begin
            @(posedge mclk);
            regAddr <= a;
            regWrite <= 1'b1;
            regWriteData <= d;
            @(posedge mclk);
            regWrite <= 1'b0;
            regWriteData <= ~d;
        end
    endtask
    task rd(input [4:0] a, output [15:0] d);
        begin
            @(posedge mclk);
            regAddr <= a;
            regRead <= 1'b1;
            @(posedge mclk);
            regRead <= 1'b0;
            @(posedge mclk);
            d = regReadValid ? regReadData : 16'hxxxx;
        end
    endtask
endmodule // mgmt_host

// File: verification/phy_clause22_mgmt_regs_tb.sv
// self-checking bench for the management register set
`timescale 1ns/1ps
module phy_clause22_mgmt_regs_tb;
    reg mclk, arst_n, strap, anEn, loopWr, loopDat, pdWr, pdDat, srWr;
    wire [4:0] regAddr;
    wire regWrite, regRead, regReadValid, srCtl, loopCtl, pdCtl, isoCtl;
    wire [15:0] regWriteData, regReadData, extCtl, extDat;
    reg [15:0] got;
    integer failures, comparisons, cycles;
    mgmt_host host (.mclk(mclk), .regReadData(regReadData), .regReadValid(regReadValid),
        .regAddr(regAddr), .regWrite(regWrite), .regWriteData(regWriteData), .regRead(regRead));
    phy_clause22_mgmt_regs #(.SOFT_RESET_CYCLES(4)) uut (
        .mclk(mclk), .arst_n(arst_n), .powerDownStrap(strap), .regAddr(regAddr),
        .regWrite(regWrite), .regWriteData(regWriteData), .regRead(regRead),
        .internalLoopbackWrite(loopWr), .internalLoopbackData(loopDat),
        .internalPowerDownWrite(pdWr), .internalPowerDownData(pdDat),
        .internalSoftResetWrite(srWr), .internal_autoneg_enable(anEn), .linkUp(1'b0),
        .autonegDone(1'b0), .regReadData(regReadData), .regReadValid(regReadValid),
        .internal_soft_reset_ctl(srCtl), .internal_pcs_loopback_ctl(loopCtl),
        .internal_power_down_ctl(pdCtl), .mii_isolate_ctl(isoCtl), .phyResetActive(),
        .extended_access_control(extCtl), .extended_access_data(extDat));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task results;
        begin
            $display("failures=%0d comparisons=%0d", failures, comparisons);
            if (failures == 0 && comparisons > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    task chk(input [15:0] g, input [15:0] e);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                failures = failures + 1;
                $display("ERROR t=%0t got %h expected %h", $time, g, e);
            end
        end
    endtask
    task rc(input [4:0] a, input [15:0] e);
        begin
            host.rd(a, got);
            chk(got, e);
        end
    endtask
    // internal side writes go through their own strobes, not the bus
    task pulse(input isPd, input d);
        begin
            @(posedge mclk);
            loopWr <= !isPd;
            pdWr <= isPd;
            loopDat <= d;
            pdDat <= d;
            @(posedge mclk);
            loopWr <= 1'b0;
            pdWr <= 1'b0;
        end
    endtask
    task doReset(input s);
        begin
            @(posedge mclk);
            arst_n <= 1'b0;
            strap <= s;
            repeat (10) @(posedge mclk);
            arst_n <= 1'b1;
            repeat (2) @(posedge mclk);
        end
    endtask
    always @(posedge mclk) begin
        cycles = cycles + 1;
        if (cycles == 2000) begin
            failures = failures + 1;
            results;
        end
    end
    initial begin
        {arst_n, strap, loopWr, loopDat, pdWr, pdDat, srWr} = 7'h00;
        anEn = 1'b1;
        {failures, comparisons, cycles} = 0;
        doReset(1'b0);
        rc(5'h00, 16'h1100);
        rc(5'h01, 16'h1009);
        rc(5'h02, 16'h1234);
        rc(5'h03, 16'h5678);
        host.wr(5'h02, 16'h0000);
        host.wr(5'h03, 16'hffff);
        rc(5'h02, 16'h1234);
        rc(5'h03, 16'h5678);
        host.wr(5'h00, 16'h7fff);
        rc(5'h00, 16'h5d00);
        chk({13'h0000, loopCtl, pdCtl, isoCtl}, 16'h0007);
        host.wr(5'h00, 16'h0000);
        rc(5'h00, 16'h1100);
        pulse(1'b0, 1'b1);
        rc(5'h00, 16'h5100);
        @(posedge mclk) anEn <= 1'b0;
        rc(5'h00, 16'h4100);
        @(posedge mclk) anEn <= 1'b1;
        pulse(1'b1, 1'b1);
        rc(5'h00, 16'h5900);
        host.wr(5'h0d, 16'habcd);
        host.wr(5'h0e, 16'h1357);
        rc(5'h0d, 16'habcd);
        rc(5'h0e, 16'h1357);
        chk(extCtl, 16'habcd);
        chk(extDat, 16'h1357);
        host.wr(5'h1f, 16'hffff);
        rc(5'h1f, 16'h0000);
        rc(5'h04, 16'h0000);
        rc(5'h0c, 16'h0000);
        // the starting write also sets loopback, power-down and isolate, which the reset must undo
        host.wr(5'h00, 16'hcc00);
        rc(5'h00, 16'hdd00);
        repeat (8) @(posedge mclk);
        rc(5'h00, 16'h1100);
        rc(5'h0d, 16'h0000);
        rc(5'h0e, 16'h0000);
        @(posedge mclk) srWr <= 1'b1;
        @(posedge mclk) srWr <= 1'b0;
        rc(5'h00, 16'h9100);
        chk({15'h0000, srCtl}, 16'h0001);
        repeat (8) @(posedge mclk);
        rc(5'h00, 16'h1100);
        doReset(1'b1);
        rc(5'h00, 16'h1900);
        results;
    end
endmodule // phy_clause22_mgmt_regs_tb
